// ==== inc/bfsp_consts.svh ====
// Named constants for the boot flash self-programming pair.
// Assumes inclusion by bare name from the package and both design ends.
`ifndef BFSP_CONSTS_SVH
`define BFSP_CONSTS_SVH

// Self-programming control register fields.
`define BFSP_CTL_SOE       0
`define BFSP_CTL_PGE       1
`define BFSP_CTL_PGW       2
`define BFSP_CTL_LOCK      3
`define BFSP_CTL_RRE       4
`define BFSP_CTL_RBF       6
`define BFSP_CTL_MASK      8'h1F

// Timed sequence: store must follow the control write within this many cycles.
`define BFSP_ARM_CYCLES    3'h4

// Operation time, counted in ticks of the calibrated RC oscillator.
`define BFSP_RC_TICK_KHZ   1000
`define BFSP_PROG_MIN_US   3700
`define BFSP_PROG_MAX_US   4500
// One extra tick covers the partial tick period in which an operation starts.
`define BFSP_PROG_TICKS    ((`BFSP_PROG_MIN_US * `BFSP_RC_TICK_KHZ + 999) / 1000 + 1)

// Flash map, word addresses.
`define BFSP_BOOT_START_11 13'h1F80
`define BFSP_BOOT_START_10 13'h1F00
`define BFSP_BOOT_START_01 13'h1E00
`define BFSP_BOOT_START_00 13'h1C00
`define BFSP_STALLED_READ_REGION_START    13'h1C00

// Pointer layout.
`define BFSP_Z_BYTE        0
`define BFSP_Z_WORD_LO     1
`define BFSP_Z_WORD_HI     6
`define BFSP_Z_PAGE_LO     7
`define BFSP_Z_PAGE_HI     13

// Controller register offsets on the AHB-Lite slave.
`define BFSP_REG_CMD       8'h00
`define BFSP_REG_ZPTR      8'h04
`define BFSP_REG_WDATA     8'h08
`define BFSP_REG_STAT      8'h0C
`define BFSP_REG_IRQ_STAT  8'h10
`define BFSP_REG_IRQ_CLR   8'h14
`define BFSP_REG_IRQ_EN    8'h18
`define BFSP_REG_LOAD      8'h1C

// Interrupt status bits.
`define BFSP_IRQ_SEQ       0
`define BFSP_IRQ_OPDONE    1
`define BFSP_IRQ_LOAD      2

`endif

// ==== inc/bfsp_pkg.sv ====
// Types shared by the self-programming device end and the core end.
// Assumes the constants header is on the include path.
`include "bfsp_consts.svh"

package bfsp_pkg;

   typedef enum logic [3:0] {
      OP_IDLE  = 4'h1,
      OP_ERASE = 4'h2,
      OP_WRITE = 4'h4,
      OP_LOCK  = 4'h8
   } bfsp_op_t;

   typedef enum logic [4:0] {
      CS_IDLE = 5'h01,
      CS_POLL = 5'h02,
      CS_EEW  = 5'h04,
      CS_CTRL = 5'h08,
      CS_EXEC = 5'h10
   } bfsp_cstate_t;

endpackage

// ==== inc/bfsp_if.sv ====
// Link between the processor core end and the flash self-programming end.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns

interface bfsp_if;
   logic        ctrl_wr;
   logic [7:0]  ctrl_wdata;
   logic [7:0]  ctrl_rdata;
   logic        store_exec;
   logic [15:0] zptr;
   logic [15:0] wdata;
   logic        eeprom_busy;
   logic        load_req;
   logic        load_ok;
   logic [7:0]  load_data;
   logic [12:0] fetch_addr;
   logic        fetch_ok;

   modport dev (
      input  ctrl_wr, ctrl_wdata, store_exec, zptr, wdata, load_req, fetch_addr,
      output ctrl_rdata, eeprom_busy, load_ok, load_data, fetch_ok
   );

   modport core (
      output ctrl_wr, ctrl_wdata, store_exec, zptr, wdata, load_req, fetch_addr,
      input  ctrl_rdata, eeprom_busy, load_ok, load_data, fetch_ok
   );
endinterface

// ==== hw/bfsp_dev.sv ====
// Flash self-programming end: control register, timed store window, page
// buffer, operation timer, boot partition map and read-region blocking.
// Assumes rc_tick_i is a one-cycle pulse per calibrated RC oscillator tick.
//
// Functional notes
// - Time operations from RC oscillator ticks.
// - Each operation lasts 3.7 to 4.5 ms.
// - Size 11: boot 0x1F80, application ends 0x1F7F.
// - Size 10: boot 0x1F00, application ends 0x1EFF.
// - Size 01: boot 0x1E00, application ends 0x1DFF.
// - Size 00: boot 0x1C00, application ends 0x1BFF.
// - Concurrent region below 0x1C00, stalled above.
// - During operation, fetch only from stalled region; a lock-bit write here leaves the concurrent region fetchable.
// - Counter 13 bits: page high, word low.
// - Pointer is counter shifted left by one.
// - Pointer bit 0 zero for stores, byte select.
// - Software zeroes word index for page write.
// - Enable bit stays set during operation; poll.
// - Software waits for EEPROM write to finish.
// - Interrupts off around the timed sequence.
// - Busy region unreadable until re-enable command.
// - Erase, re-enable, fill, write, re-enable again.
// - Store counts only within four cycles.
// - Region busy flag holds while region busy.
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "bfsp_consts.svh"

module bfsp_dev
   import bfsp_pkg::*;
#(
   parameter int PROG_TICKS = `BFSP_PROG_TICKS
)(
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Link to the core.
   bfsp_if.dev              lnk,
   // Timing source and straps.
   input  wire logic        rc_tick_i,
   input  wire logic [1:0]  boot_size_i,
   input  wire logic        eeprom_write_busy_i,
   // Flash array side.
   input  wire logic [15:0] flash_rd_data_i,
   output logic [12:0]      flash_rd_addr_o,
   output logic             flash_erase_o,
   output logic             flash_write_o,
   output logic             flash_lock_o,
   output logic [6:0]       flash_page_o,
   output logic [7:0]       lock_bits_o,
   output logic             op_done_o,
   input  wire logic [5:0]  buf_rd_idx_i,
   output logic [15:0]      buf_rd_data_o,
   // Boot partition.
   output logic [12:0]      boot_start_o,
   output logic [12:0]      app_end_o
);

   function automatic logic [12:0] boot_start(input logic [1:0] sz);
      logic [12:0] s;
      s = `BFSP_BOOT_START_00;
      unique case (sz)
         2'h3: s = `BFSP_BOOT_START_11;
         2'h2: s = `BFSP_BOOT_START_10;
         2'h1: s = `BFSP_BOOT_START_01;
         2'h0: s = `BFSP_BOOT_START_00;
      endcase
      return s;
   endfunction

   // True for word addresses inside the concurrent-read region.
   function automatic logic in_rww(input logic [12:0] addr);
      return addr < `BFSP_STALLED_READ_REGION_START;
   endfunction

   logic [7:0]  cmd;
   logic [2:0]  arm_cnt;
   bfsp_op_t    op;
   logic [11:0] tick_cnt;
   logic        region_busy;
   logic [15:0] pbuf [64];
   logic        ctrl_take;
   logic        exec_hit;
   logic        op_end;
   logic [12:0] load_addr;

   // A new command is only accepted when idle and the EEPROM is quiet.
   assign ctrl_take = lnk.ctrl_wr && (op == OP_IDLE) && !eeprom_write_busy_i
                      && !cmd[`BFSP_CTL_SOE];
   assign exec_hit  = lnk.store_exec && (arm_cnt != 3'h0)
                      && !lnk.zptr[`BFSP_Z_BYTE];
   assign op_end    = (op != OP_IDLE) && rc_tick_i
                      && (tick_cnt == 12'(PROG_TICKS - 1));

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd     <= 8'h00;
         arm_cnt <= 3'h0;
      end else if (ctrl_take) begin
         cmd     <= lnk.ctrl_wdata & `BFSP_CTL_MASK;
         arm_cnt <= `BFSP_ARM_CYCLES;
      end else if (exec_hit) begin
         cmd     <= 8'h00;
         arm_cnt <= 3'h0;
      end else if (arm_cnt != 3'h0) begin
         arm_cnt <= arm_cnt - 3'h1;
         if (arm_cnt == 3'h1) begin
            cmd <= 8'h00;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op           <= OP_IDLE;
         flash_page_o <= 7'h00;
         lock_bits_o  <= 8'h00;
      end else if (exec_hit && cmd[`BFSP_CTL_PGE]) begin
         op           <= OP_ERASE;
         flash_page_o <= lnk.zptr[`BFSP_Z_PAGE_HI:`BFSP_Z_PAGE_LO];
      end else if (exec_hit && cmd[`BFSP_CTL_PGW]) begin
         op           <= OP_WRITE;
         flash_page_o <= lnk.zptr[`BFSP_Z_PAGE_HI:`BFSP_Z_PAGE_LO];
      end else if (exec_hit && cmd[`BFSP_CTL_LOCK]) begin
         op           <= OP_LOCK;
         lock_bits_o  <= lnk.wdata[7:0];
      end else if (op_end) begin
         op <= OP_IDLE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= 12'h000;
      end else if (op == OP_IDLE) begin
         tick_cnt <= 12'h000;
      end else if (rc_tick_i) begin
         tick_cnt <= op_end ? 12'h000 : tick_cnt + 12'h001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_done_o <= 1'b0;
      end else begin
         op_done_o <= op_end;
      end
   end

   // Erase and write block the concurrent region until software re-enables it.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         region_busy <= 1'b0;
      end else if (exec_hit && (cmd[`BFSP_CTL_PGE] || cmd[`BFSP_CTL_PGW])) begin
         region_busy <= 1'b1;
      end else if (exec_hit && cmd[`BFSP_CTL_RRE] && !cmd[`BFSP_CTL_LOCK]) begin
         region_busy <= 1'b0;
      end
   end

   // A plain store fills one word of the temporary page buffer.
   always_ff @(posedge mclk_i) begin
      if (exec_hit && ((cmd & `BFSP_CTL_MASK) == 8'h01)) begin
         pbuf[lnk.zptr[`BFSP_Z_WORD_HI:`BFSP_Z_WORD_LO]] <= lnk.wdata;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_rd_data_o <= 16'h0000;
      end else begin
         buf_rd_data_o <= pbuf[buf_rd_idx_i];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_start_o <= `BFSP_BOOT_START_00;
         app_end_o    <= `BFSP_BOOT_START_00 - 13'h0001;
      end else begin
         boot_start_o <= boot_start(boot_size_i);
         app_end_o    <= boot_start(boot_size_i) - 13'h0001;
      end
   end

   assign flash_erase_o = (op == OP_ERASE);
   assign flash_write_o = (op == OP_WRITE);
   assign flash_lock_o  = (op == OP_LOCK);

   assign load_addr       = lnk.zptr[`BFSP_Z_PAGE_HI:`BFSP_Z_WORD_LO];
   assign flash_rd_addr_o = load_addr;
   assign lnk.load_ok     = !(region_busy && in_rww(load_addr));
   assign lnk.load_data   = lnk.zptr[`BFSP_Z_BYTE] ? flash_rd_data_i[15:8]
                                                   : flash_rd_data_i[7:0];
   assign lnk.fetch_ok    = !(region_busy && in_rww(lnk.fetch_addr));
   assign lnk.eeprom_busy = eeprom_write_busy_i;

   // Enable bit reads set while armed and throughout any operation.
   always_comb begin
      lnk.ctrl_rdata                 = cmd;
      lnk.ctrl_rdata[`BFSP_CTL_SOE]  = cmd[`BFSP_CTL_SOE] || (op != OP_IDLE);
      lnk.ctrl_rdata[`BFSP_CTL_RBF]  = region_busy;
   end

endmodule

// ==== hw/bfsp_core.sv ====
// Core end: AHB-Lite register slave that runs the store sequence and loads.
// Assumes a single AHB-Lite master, word transfers, hclk equal to mclk_i.
`timescale 1ns/1ns
`include "bfsp_consts.svh"

module bfsp_core
   import bfsp_pkg::*;
(
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // AHB-Lite slave.
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // Instruction fetch and interrupt.
   input  wire logic [12:0] fetch_addr_i,
   output logic             fetch_ok_o,
   output logic             irq_o,
   // Link to the flash end.
   bfsp_if.core             lnk
);

   bfsp_cstate_t st;
   logic [7:0]   cmd_val;
   logic [15:0]  zptr;
   logic [15:0]  wdata;
   logic [2:0]   irq_st;
   logic [2:0]   irq_en;
   logic [7:0]   load_byte;
   logic         load_pend;
   logic         soe_q;
   logic         wr_ph;
   logic [7:0]   addr_ph;
   logic         wr_en;

   // Address phase captured; the slave never inserts wait states.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ph   <= 1'b0;
         addr_ph <= 8'h00;
      end else if (hready_i) begin
         wr_ph   <= hsel_i && htrans_i[1] && hwrite_i;
         addr_ph <= haddr_i[7:0];
      end
   end

   assign wr_en       = wr_ph;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zptr  <= 16'h0000;
         wdata <= 16'h0000;
      end else if (wr_en && (addr_ph == `BFSP_REG_ZPTR)) begin
         zptr  <= {hwdata_i[15:1], hwdata_i[0]};
      end else if (wr_en && (addr_ph == `BFSP_REG_WDATA)) begin
         wdata <= hwdata_i[15:0];
      end
   end

   // Store sequence: poll enable bit, wait EEPROM, control write, store.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st      <= CS_IDLE;
         cmd_val <= 8'h00;
      end else begin
         unique case (st)
            CS_IDLE: begin
               if (wr_en && (addr_ph == `BFSP_REG_CMD)) begin
                  cmd_val <= hwdata_i[7:0] | 8'h01;
                  st      <= CS_POLL;
               end
            end
            CS_POLL: begin
               if (!lnk.ctrl_rdata[`BFSP_CTL_SOE]) begin
                  st <= CS_EEW;
               end
            end
            CS_EEW: begin
               if (!lnk.eeprom_busy) begin
                  st <= CS_CTRL;
               end
            end
            CS_CTRL: st <= CS_EXEC;
            CS_EXEC: st <= CS_IDLE;
         endcase
      end
   end

   assign lnk.ctrl_wr    = (st == CS_CTRL);
   assign lnk.ctrl_wdata = cmd_val;
   assign lnk.store_exec = (st == CS_EXEC);
   assign lnk.wdata      = wdata;
   // The pointer goes out as software wrote it; the flash end refuses an odd store.
   assign lnk.zptr       = zptr;
   assign lnk.fetch_addr = fetch_addr_i;
   assign fetch_ok_o     = lnk.fetch_ok;

   // A load waits while its word lies in a blocked region.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_pend <= 1'b0;
         load_byte <= 8'h00;
      end else if (load_pend && lnk.load_ok && (st == CS_IDLE)) begin
         load_pend <= 1'b0;
         load_byte <= lnk.load_data;
      end else if (wr_en && (addr_ph == `BFSP_REG_LOAD)) begin
         load_pend <= 1'b1;
      end
   end

   assign lnk.load_req = load_pend && (st == CS_IDLE);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soe_q <= 1'b0;
      end else begin
         soe_q <= lnk.ctrl_rdata[`BFSP_CTL_SOE];
      end
   end

   // Sticky events; a set in the same cycle as a clear wins.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_st <= 3'h0;
         irq_en <= 3'h0;
      end else begin
         irq_st <= (irq_st & ~((wr_en && (addr_ph == `BFSP_REG_IRQ_CLR)) ? hwdata_i[2:0] : 3'h0))
                   | {lnk.load_req && lnk.load_ok,
                      soe_q && !lnk.ctrl_rdata[`BFSP_CTL_SOE],
                      st == CS_EXEC};
         if (wr_en && (addr_ph == `BFSP_REG_IRQ_EN)) begin
            irq_en <= hwdata_i[2:0];
         end
      end
   end

   // The interrupt is held off across the timed control-write/store pair.
   assign irq_o = |(irq_st & irq_en) && (st != CS_CTRL) && (st != CS_EXEC);

   always_comb begin
      unique case (addr_ph)
         `BFSP_REG_CMD:      hrdata_o = {24'h000000, cmd_val};
         `BFSP_REG_ZPTR:     hrdata_o = {16'h0000, zptr};
         `BFSP_REG_WDATA:    hrdata_o = {16'h0000, wdata};
         `BFSP_REG_STAT:     hrdata_o = {16'h0000, load_byte, lnk.ctrl_rdata[7:4],
                                         lnk.eeprom_busy, load_pend, st != CS_IDLE,
                                         lnk.ctrl_rdata[`BFSP_CTL_SOE]};
         `BFSP_REG_IRQ_STAT: hrdata_o = {29'h00000000, irq_st};
         `BFSP_REG_IRQ_EN:   hrdata_o = {29'h00000000, irq_en};
         `BFSP_REG_LOAD:     hrdata_o = {24'h000000, load_byte};
         default:            hrdata_o = 32'h00000000;
      endcase
   end

endmodule

// ==== bench/bfsp_sva.sv ====
// Concurrent checks on the link between the core end and the flash end.
// Assumes instantiation beside the link interface, on the core clock.
`timescale 1ns/1ns

module bfsp_sva (
   // Clock and reset.
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   // Link signals.
   input wire logic        ctrl_wr,
   input wire logic [7:0]  ctrl_rdata,
   input wire logic        store_exec,
   input wire logic [15:0] zptr,
   input wire logic        eeprom_busy,
   input wire logic        load_ok,
   input wire logic [12:0] fetch_addr,
   input wire logic        fetch_ok
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   a_fetch_blocked: assert property (ctrl_rdata[6] && fetch_addr < 13'h1C00 |-> !fetch_ok)
      else $error("fetch granted from busy region");
   a_fetch_stalled: assert property (fetch_addr >= 13'h1C00 |-> fetch_ok)
      else $error("fetch refused in stalled region");
   a_fetch_free: assert property (!ctrl_rdata[6] |-> fetch_ok)
      else $error("fetch refused while region idle");
   a_load_blocked: assert property (ctrl_rdata[6] && zptr[13:1] < 13'h1C00 |-> !load_ok)
      else $error("load granted from busy region");
   a_busy_cause: assert property ($rose(ctrl_rdata[6]) |-> $past(store_exec))
      else $error("region busy without store");
   a_busy_release: assert property ($fell(ctrl_rdata[6]) |-> $past(store_exec))
      else $error("region busy cleared without store");
   a_enable_holds: assert property ($rose(ctrl_rdata[6]) |-> ctrl_rdata[0] [*8])
      else $error("enable dropped during operation");
   a_store_follows: assert property (ctrl_wr |=> store_exec)
      else $error("store missed the timed window");
   a_eeprom_quiet: assert property (ctrl_wr |-> !eeprom_busy)
      else $error("control write during eeprom write");
   a_poll_first: assert property (ctrl_wr |-> !ctrl_rdata[0])
      else $error("control write while enable set");
   a_odd_refused: assert property (store_exec && zptr[0] |=> !$rose(ctrl_rdata[6]) ##[0:5] !ctrl_rdata[0])
      else $error("store with odd pointer acted");
endmodule

// ==== bench/boot_flash_self_program_map_tb.sv ====
// Testbench: core end and flash end joined by the link, driven over AHB-Lite.
// Assumes an RC tick every 20 core clocks and a short operation count.
`timescale 1ns/1ns

module boot_flash_self_program_map_tb;
   localparam int PT = 8;
   logic        mclk_i;
   logic        rst_n_i = 1'b0;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'b00;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic        rc      = 1'b0;
   logic        eew     = 1'b0;
   logic [1:0]  bsz     = 2'b00;
   logic [12:0] fa      = 13'h1C00;
   logic [5:0]  bix     = 6'h00;
   logic        hrdy, hresp, irq, fok, ers, wrt, done, srdy, lck;
   logic [31:0] hrdata, sd, q;
   logic [12:0] bst, aend, fra;
   logic [6:0]  pg;
   logic [7:0]  lkb;
   logic [15:0] bdat;
   int          fail_count = 0;
   int          cmp_count  = 0;
   int          nt = 0;
   int          rdv = 0;
   int          n, t0;

   bfsp_if bfsp_if_i ();
   bfsp_core bfsp_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
      .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .fetch_addr_i(fa), .fetch_ok_o(fok),
      .irq_o(irq), .lnk(bfsp_if_i));
   bfsp_dev #(.PROG_TICKS(PT)) bfsp_dev_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .lnk(bfsp_if_i),
      .rc_tick_i(rc), .boot_size_i(bsz), .eeprom_write_busy_i(eew), .flash_rd_data_i(16'h5AC3),
      .flash_rd_addr_o(fra), .flash_erase_o(ers), .flash_write_o(wrt), .flash_lock_o(lck), .flash_page_o(pg),
      .lock_bits_o(lkb), .op_done_o(done), .buf_rd_idx_i(bix), .buf_rd_data_o(bdat),
      .boot_start_o(bst), .app_end_o(aend));
   bfsp_sva bfsp_sva_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ctrl_wr(bfsp_if_i.ctrl_wr),
      .ctrl_rdata(bfsp_if_i.ctrl_rdata), .store_exec(bfsp_if_i.store_exec), .zptr(bfsp_if_i.zptr),
      .eeprom_busy(bfsp_if_i.eeprom_busy), .load_ok(bfsp_if_i.load_ok),
      .fetch_addr(bfsp_if_i.fetch_addr), .fetch_ok(bfsp_if_i.fetch_ok));

   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // RC tick divider; nt counts the ticks seen at each edge.
   always @(posedge mclk_i) begin
      rdv  <= (rdv == 19) ? 0 : rdv + 1;
      rc   <= (rdv == 19);
      nt   <= nt + (rc ? 1 : 0);
      srdy <= hrdy;
      sd   <= hrdata;
   end

   task automatic tk(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do tk(1); while (srdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do tk(1); while (srdy !== 1'b1);
      q = sd;
   endtask

   task automatic wst(input logic [31:0] m, input logic [31:0] v);
      tk(6);
      n = 0;
      do begin
         ahb(1'b0, 8'h0C, 32'h0);
         n++;
      end while ((q & m) !== v && n < 500);
      chk(q & m, v);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      tk(1);
      for (int s = 0; s < 4; s++) begin
         bsz <= s[1:0];
         tk(2);
         chk({19'h0, bst}, 32'h2000 - (32'h400 >> s));
         chk({19'h0, aend}, 32'h1FFF - (32'h400 >> s));
      end
      ahb(1'b1, 8'h18, 32'h2);
      ahb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h2);
      ahb(1'b0, 8'h24, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      for (int i = 0; i < 2; i++) begin
         ahb(1'b1, 8'h04, i ? 32'h7E : 32'h6);
         ahb(1'b1, 8'h08, i ? 32'hBEEF : 32'h1234);
         ahb(1'b1, 8'h00, 32'h01);
         wst(32'h3, 32'h0);
         bix <= i ? 6'h3F : 6'h03;
         tk(2);
         chk({16'h0, bdat}, i ? 32'hBEEF : 32'h1234);
      end
      ahb(1'b1, 8'h14, 32'h7);
      tk(1);
      chk({31'h0, irq}, 32'h0);
      // Page erase of page 0x55, timed in RC ticks.
      ahb(1'b1, 8'h04, 32'h2A80);
      ahb(1'b1, 8'h00, 32'h03);
      for (n = 0; n < 20 && ers !== 1'b1; n++) tk(1);
      t0 = nt;
      chk({25'h0, pg}, 32'h55);
      fa <= 13'h1BFF;
      tk(1);
      chk({31'h0, fok}, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(q & 32'h41, 32'h41);
      for (n = 0; n < 400 && ers === 1'b1; n++) tk(1);
      chk(nt - t0, PT);
      chk({31'h0, done}, 32'h1);
      tk(1);
      chk({31'h0, fok}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b1, 8'h1C, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(q & 32'h44, 32'h44);
      ahb(1'b1, 8'h14, 32'h2);
      tk(1);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, 8'h00, 32'h11);
      wst(32'h47, 32'h0);
      chk({31'h0, fok}, 32'h1);
      ahb(1'b0, 8'h1C, 32'h0);
      chk(q & 32'hFF, 32'hC3);
      ahb(1'b1, 8'h04, 32'h2A81);
      chk({19'h0, fra}, 32'h1540);
      ahb(1'b1, 8'h1C, 32'h0);
      wst(32'h4, 32'h0);
      ahb(1'b0, 8'h1C, 32'h0);
      chk(q & 32'hFF, 32'h5A);
      // A store with pointer bit 0 set must expire without action.
      ahb(1'b1, 8'h04, 32'h0001);
      ahb(1'b1, 8'h00, 32'h03);
      wst(32'h43, 32'h0);
      chk({31'h0, ers}, 32'h0);
      // Lock-bit write: timed like an erase, but the region stays readable.
      ahb(1'b1, 8'h04, 32'h0000);
      ahb(1'b1, 8'h08, 32'h00A5);
      ahb(1'b1, 8'h00, 32'h09);
      for (n = 0; n < 20 && lck !== 1'b1; n++) tk(1);
      t0 = nt;
      chk({24'h0, lkb}, 32'hA5);
      chk({31'h0, fok}, 32'h1);
      for (n = 0; n < 400 && lck === 1'b1; n++) tk(1);
      chk(nt - t0, PT);
      chk({31'h0, done}, 32'h1);
      eew <= 1'b1;
      ahb(1'b1, 8'h04, 32'h2A80);
      ahb(1'b1, 8'h00, 32'h05);
      tk(20);
      chk({31'h0, wrt}, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(q & 32'hA, 32'hA);
      eew <= 1'b0;
      for (n = 0; n < 20 && wrt !== 1'b1; n++) tk(1);
      chk({31'h0, wrt}, 32'h1);
      chk({25'h0, pg}, 32'h55);
      for (n = 0; n < 400 && wrt === 1'b1; n++) tk(1);
      chk({31'h0, done}, 32'h1);
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      end_of_test;
   end
endmodule
